// *** pkg/upes_consts.svh ***
// constants for the pipe event status block
// Notes on behaviour
// R1 - not-ready event on a pipe in buffer mode sets its status; enabled raises interrupt.
// R2 - no not-ready events in host setup transactions or function status stage.
// R3 - host: three consecutive timeouts or errors give not-ready and force response NAK.
// R4 - host: STALL handshake on non-setup transaction gives not-ready, response STALL.
// R5 - function transmit pipe: IN token with empty buffer gives not-ready at token.
// R6 - function receive pipe: OUT with full buffer gives not-ready on NAK, not retries/errors.
// R7 - buffer-empty event on buffer-mode pipe sets status; enabled raises interrupt.
// R8 - transmit: empty after sent packet gives buffer-empty; single buffer matches buffer-ready.
// R9 - no buffer-empty on double-buffer refill, buffer clear, or function status ZLP.
// R10 - receive oversize packet gives buffer-empty, drops data, response STALL.
// R11 - oversize buffer-empty suppressed on CRC or stuffing error and during setup.
// R12 - software clears buffer-empty status by writing 0; writing 1 keeps it.
// R13 - function role tracks device state, enabled transition interrupts, three-bit field.
// R14 - transition to default state reported only after bus reset detected.
// R15 - leaving suspend on resume goes to the resume interrupt, not state interrupt.
// R16 - function role sequences control stages, enabled interrupts, three-bit stage field.
// R17 - any control sequence error sets control pipe response to STALL with upper bit 1.
// R18 - control read errors: OUT before IN data, IN in status, DATA0 in status.
// R19 - control write errors: IN before OUT acked, DATA0 first packet, OUT in status.
// R20 - no-data control: OUT token in status stage is a sequence error.
// R21 - excess write data is not an error; read status non-zero packets end normally.
// R22 - error code held in stage field until clear; setup end held until then.
// R23 - interrupt output high while any enabled summary flag is set.
`ifndef UPES_CONSTS_SVH
`define UPES_CONSTS_SVH
`define UPES_A_MAIN_STS   4'h0
`define UPES_A_MAIN_ENB   4'h1
`define UPES_A_NOT_READY_EVENT_STS   4'h2
`define UPES_A_NOT_READY_EVENT_ENB   4'h3
`define UPES_A_BUFFER_EMPTY_EVENT_STS   4'h4
`define UPES_A_BUFFER_EMPTY_EVENT_ENB   4'h5
`define UPES_A_PIPE_RESP  4'h6
`define UPES_A_CTRL       4'h7
`define UPES_RESP_NAK     2'h0
`define UPES_RESP_BUF     2'h1
`define UPES_RESP_STALL   2'h3
`define UPES_RESP_STALL_E 2'h2
`define UPES_FAIL_LIMIT   2'h3
`define UPES_STG_IDLE     3'h0
`define UPES_STG_RD_DATA  3'h1
`define UPES_STG_RD_STAT  3'h2
`define UPES_STG_WR_DATA  3'h3
`define UPES_STG_WR_STAT  3'h4
`define UPES_STG_ND_STAT  3'h5
`define UPES_STG_ERR      3'h6
`define UPES_DEV_POWERED  3'h0
`define UPES_DEV_DEFAULT  3'h1
`define UPES_DEV_ADDRESS  3'h2
`define UPES_DEV_CONFIG   3'h3
`define UPES_DEV_SUSP     3'h4
// main status bit positions
`define UPES_B_NOT_READY_EVENT       0
`define UPES_B_BUFFER_EMPTY_EVENT       1
`define UPES_B_DVST       2
`define UPES_B_STAGE_TRANSITION_EVENT       3
`define UPES_B_RESM       4
`define UPES_B_SEQUENCE_ERROR_FLAG       5
`define UPES_F_DVSQ_LO    8
`define UPES_F_CTSQ_LO    12
`endif

// *** pkg/upes_pkg.sv ***
// types for the pipe event status block
package upes_pkg;
  // one link event for one pipe
  typedef struct packed {
    logic [2:0] pipe;
    logic       is_tx;
    logic       in_setup;
    logic       timeout_err;
    logic       handshake_ok;
    logic       stall_hs;
    logic       in_token;
    logic       out_nak;
    logic       toggle_miss;
    logic       data_err;
    logic       buf_has_data;
    logic       tx_done;
    logic       tx_zlp_status;
    logic       dbl_refill;
    logic       oversize;
  } upes_link_ev_t;
  // control transfer events, function role
  typedef struct packed {
    logic setup_done;
    logic dir_read;
    logic no_data;
    logic in_tok;
    logic out_tok;
    logic data0;
    logic in_data_sent;
    logic out_acked;
    logic status_done;
  } upes_ctl_ev_t;
  // device state events, function role
  typedef struct packed {
    logic bus_reset;
    logic addressed;
    logic configured;
    logic suspend;
    logic resume;
  } upes_dev_ev_t;
  typedef enum logic [3:0] {
    UPES_ST_IDLE = 4'b0001,
    UPES_ST_DATA = 4'b0010,
    UPES_ST_STAT = 4'b0100,
    UPES_ST_ERR  = 4'b1000
  } upes_stage_t;
endpackage

// *** hdl/upes_top.sv ***
// pipe not-ready, buffer-empty, device state and control stage status
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "upes_consts.svh"
module upes_top
  import upes_pkg::*;
#(
  parameter int NPIPE = 8
) (
  input  wire logic          MCLK,
  input  wire logic          RST_N,
  input  wire logic          HOST_ROLE,
  input  wire upes_link_ev_t LINK_EV,
  input  wire logic          LINK_EV_VALID,
  input  wire upes_ctl_ev_t  CTL_EV,
  input  wire upes_dev_ev_t  DEV_EV,
  input  wire logic          BUF_CLEAR,
  input  wire logic [2:0]    BUF_CLEAR_PIPE,
  input  wire logic [3:0]    AVS_ADDRESS,
  input  wire logic          AVS_READ,
  input  wire logic          AVS_WRITE,
  input  wire logic [31:0]   AVS_WRITEDATA,
  input  wire logic [3:0]    AVS_BYTEENABLE,
  output logic [31:0]        AVS_READDATA,
  output logic               AVS_WAITREQUEST,
  output logic               STALL_REPLY,
  output logic               USB_IRQ
);
  logic [NPIPE-1:0]   not_ready_event_sts_r, not_ready_event_enb_r, buffer_empty_event_sts_r, buffer_empty_event_enb_r;
  logic [NPIPE-1:0]   not_ready_event_set, buffer_empty_event_set, not_ready_event_clr, buffer_empty_event_clr;
  logic [2*NPIPE-1:0] resp_r;
  logic [1:0]         fail_cnt_r [NPIPE];
  logic [5:0]         main_enb_r;
  logic               dvst_r, stage_transition_event_r, resm_r, sequence_error_flag_r, setup_pend_r, ack_r;
  logic [2:0]         dvsq_r, ctsq_r;
  upes_stage_t        stage_r;
  logic               read_xfer_r, nodata_r, got_data_r;
  logic [31:0]        rdata_r;
  logic               ctl_err;

  // bus slave: one wait cycle on every access, answer on the second
  wire acc = (AVS_READ | AVS_WRITE) & ~ack_r;
  wire wr  = AVS_WRITE & ack_r;
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_r;
  assign AVS_READDATA    = rdata_r;
  wire wr_nsts = wr & (AVS_ADDRESS == `UPES_A_NOT_READY_EVENT_STS) & AVS_BYTEENABLE[0];
  wire wr_bsts = wr & (AVS_ADDRESS == `UPES_A_BUFFER_EMPTY_EVENT_STS) & AVS_BYTEENABLE[0];
  wire wr_main = wr & (AVS_ADDRESS == `UPES_A_MAIN_STS) & AVS_BYTEENABLE[0];
  wire wr_resp = wr & (AVS_ADDRESS == `UPES_A_PIPE_RESP) & AVS_BYTEENABLE[0];

  // per-pipe event decode
  wire [2:0] p = LINK_EV.pipe;
  wire ev = LINK_EV_VALID;
  wire pbuf = (resp_r[2*p +: 2] == `UPES_RESP_BUF);
  wire in_fn_status = ~HOST_ROLE & (p == 3'h0) &
                      ((stage_r == UPES_ST_STAT) | (stage_r == UPES_ST_ERR));
  wire nr_block = (HOST_ROLE & LINK_EV.in_setup) | in_fn_status; // [R2]
  wire fail_ev = ev & HOST_ROLE & ~LINK_EV.in_setup & LINK_EV.timeout_err;
  wire fail_3  = fail_ev & (fail_cnt_r[p] == `UPES_FAIL_LIMIT - 2'h1); // [R3]
  wire stall_ev = ev & HOST_ROLE & ~LINK_EV.in_setup & LINK_EV.stall_hs; // [R4]
  wire fn_in  = ev & ~HOST_ROLE & LINK_EV.is_tx & LINK_EV.in_token
              & ~LINK_EV.buf_has_data; // [R5]
  wire fn_out = ev & ~HOST_ROLE & ~LINK_EV.is_tx & LINK_EV.out_nak
              & ~LINK_EV.toggle_miss & ~LINK_EV.data_err; // [R6]
  wire not_ready_event_ev = (fail_3 | stall_ev | fn_in | fn_out) & ~nr_block;
  wire buffer_empty_event_tx = ev & LINK_EV.is_tx & LINK_EV.tx_done & ~LINK_EV.buf_has_data
               & ~LINK_EV.dbl_refill & ~LINK_EV.tx_zlp_status
               & ~(BUF_CLEAR & BUF_CLEAR_PIPE == p); // [R8] [R9]
  wire buffer_empty_event_rx = ev & ~LINK_EV.is_tx & LINK_EV.oversize & ~LINK_EV.data_err
               & ~LINK_EV.in_setup; // [R10] [R11]
  assign STALL_REPLY = buffer_empty_event_rx & ~HOST_ROLE & pbuf; // [R10]

  genvar g;
  generate
    for (g = 0; g < NPIPE; g++) begin : g_pipe
      wire hit = (p == 3'(g));
      assign not_ready_event_set[g] = not_ready_event_ev & hit & pbuf; // [R1]
      assign buffer_empty_event_set[g] = (buffer_empty_event_tx | buffer_empty_event_rx) & hit & pbuf; // [R7]
      assign not_ready_event_clr[g] = wr_nsts & ~AVS_WRITEDATA[g];
      assign buffer_empty_event_clr[g] = wr_bsts & ~AVS_WRITEDATA[g]; // [R12]
      wire [1:0] resp_nxt =
        (hit & pbuf & (stall_ev | buffer_empty_event_rx)) ? `UPES_RESP_STALL :
        (hit & pbuf & fail_3) ? `UPES_RESP_NAK :
        (g == 0 && ctl_err) ? `UPES_RESP_STALL_E :
        (wr_resp & AVS_BYTEENABLE[g/4]) ? AVS_WRITEDATA[2*g +: 2] :
        resp_r[2*g +: 2];
      always_ff @(posedge MCLK) begin
        if (!RST_N) begin
          resp_r[2*g +: 2] <= `UPES_RESP_NAK;
          fail_cnt_r[g]    <= 2'h0;
        end else begin
          resp_r[2*g +: 2] <= resp_nxt; // [R3] [R4] [R17]
          if (hit & ev & HOST_ROLE & ~LINK_EV.in_setup)
            fail_cnt_r[g] <= fail_3 ? 2'h0 :
                             LINK_EV.timeout_err ? fail_cnt_r[g] + 2'h1 :
                             LINK_EV.handshake_ok ? 2'h0 : fail_cnt_r[g];
        end
      end
    end
  endgenerate

  // control stage sequencing, function role only
  wire fn = ~HOST_ROLE;
  wire in_data = stage_r == UPES_ST_DATA;
  wire in_stat = stage_r == UPES_ST_STAT;
  wire err_rd = read_xfer_r & ((in_data & CTL_EV.out_tok & ~got_data_r)
              | (in_stat & (CTL_EV.in_tok | CTL_EV.data0))); // [R18]
  wire err_wr = ~read_xfer_r & ~nodata_r & ((in_data & CTL_EV.in_tok & ~got_data_r)
              | (in_data & CTL_EV.data0 & ~got_data_r)
              | (in_stat & CTL_EV.out_tok)); // [R19] [R21]
  wire err_nd = nodata_r & in_stat & CTL_EV.out_tok; // [R20]
  assign ctl_err = fn & (err_rd | err_wr | err_nd);
  wire held = (ctsq_r == `UPES_STG_ERR) & stage_transition_event_r;
  wire setup_go = fn & (CTL_EV.setup_done | (setup_pend_r & ~held)) & ~held; // [R22]
  wire stg_step = fn & ~ctl_err & ~setup_go & (
                  (in_data & ((read_xfer_r & CTL_EV.out_tok & got_data_r)
                  | (~read_xfer_r & CTL_EV.in_tok & got_data_r)))
                  | (in_stat & CTL_EV.status_done));
  wire [2:0] stg_code =
    ~in_data ? `UPES_STG_IDLE :
    read_xfer_r ? `UPES_STG_RD_STAT : `UPES_STG_WR_STAT;
  wire [2:0] setup_code =
    CTL_EV.no_data ? `UPES_STG_ND_STAT :
    CTL_EV.dir_read ? `UPES_STG_RD_DATA : `UPES_STG_WR_DATA;
  wire main_clr_stage_transition_event = wr_main & ~AVS_WRITEDATA[`UPES_B_STAGE_TRANSITION_EVENT];

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      stage_r      <= UPES_ST_IDLE;
      ctsq_r       <= `UPES_STG_IDLE;
      read_xfer_r  <= 1'b0;
      nodata_r     <= 1'b0;
      got_data_r   <= 1'b0;
      setup_pend_r <= 1'b0;
      stage_transition_event_r       <= 1'b0;
      sequence_error_flag_r       <= 1'b0;
    end else begin
      if (ctl_err) begin
        stage_r <= UPES_ST_ERR;
        ctsq_r  <= `UPES_STG_ERR; // [R17] [R22]
        sequence_error_flag_r  <= 1'b1;
      end else if (setup_go) begin
        stage_r     <= CTL_EV.no_data ? UPES_ST_STAT : UPES_ST_DATA;
        ctsq_r      <= setup_code; // [R16]
        read_xfer_r <= CTL_EV.dir_read;
        nodata_r    <= CTL_EV.no_data;
        got_data_r  <= 1'b0;
      end else if (stg_step) begin
        stage_r <= in_data ? UPES_ST_STAT : UPES_ST_IDLE;
        ctsq_r  <= stg_code;
      end else if (in_data & (CTL_EV.in_data_sent | CTL_EV.out_acked)) begin
        got_data_r <= 1'b1;
      end
      // held setup end stays pending while the error code is kept
      if (fn & CTL_EV.setup_done & held)
        setup_pend_r <= 1'b1;
      else if (setup_go)
        setup_pend_r <= 1'b0;
      if (ctl_err | setup_go | stg_step)
        stage_transition_event_r <= 1'b1; // [R16]
      else if (main_clr_stage_transition_event)
        stage_transition_event_r <= 1'b0;
      if (wr_main & ~AVS_WRITEDATA[`UPES_B_SEQUENCE_ERROR_FLAG] & ~ctl_err)
        sequence_error_flag_r <= 1'b0;
    end
  end

  // device state, function role only
  wire [2:0] dv_nxt =
    DEV_EV.bus_reset  ? `UPES_DEV_DEFAULT :
    DEV_EV.suspend    ? `UPES_DEV_SUSP :
    DEV_EV.configured ? `UPES_DEV_CONFIG :
    DEV_EV.addressed  ? `UPES_DEV_ADDRESS : dvsq_r;
  logic [2:0] pre_susp_r;
  wire dv_ev = fn & (DEV_EV.bus_reset | DEV_EV.suspend
                     | DEV_EV.configured | DEV_EV.addressed); // [R13] [R14]
  wire rs_ev = fn & DEV_EV.resume & (dvsq_r == `UPES_DEV_SUSP); // [R15]

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      dvsq_r     <= `UPES_DEV_POWERED;
      pre_susp_r <= `UPES_DEV_POWERED;
      dvst_r     <= 1'b0;
      resm_r     <= 1'b0;
    end else begin
      if (dv_ev) begin
        dvsq_r <= dv_nxt;
        if (DEV_EV.suspend) pre_susp_r <= dvsq_r;
      end else if (rs_ev) begin
        dvsq_r <= pre_susp_r;
      end
      if (dv_ev) dvst_r <= 1'b1;
      else if (wr_main & ~AVS_WRITEDATA[`UPES_B_DVST]) dvst_r <= 1'b0;
      if (rs_ev) resm_r <= 1'b1;
      else if (wr_main & ~AVS_WRITEDATA[`UPES_B_RESM]) resm_r <= 1'b0;
    end
  end

  // status, enables and summary flags
  wire not_ready_event_sum = |(not_ready_event_sts_r & not_ready_event_enb_r);
  wire buffer_empty_event_sum = |(buffer_empty_event_sts_r & buffer_empty_event_enb_r);
  wire [5:0] main_flags = {sequence_error_flag_r, resm_r, stage_transition_event_r, dvst_r, buffer_empty_event_sum, not_ready_event_sum};
  assign USB_IRQ = |(main_flags & main_enb_r); // [R1] [R7] [R23]

  wire [31:0] rd_mux =
    (AVS_ADDRESS == `UPES_A_MAIN_STS) ? {16'h0, 1'b0, ctsq_r, 1'b0, dvsq_r,
                                          2'h0, main_flags} :
    (AVS_ADDRESS == `UPES_A_MAIN_ENB) ? {26'h0, main_enb_r} :
    (AVS_ADDRESS == `UPES_A_NOT_READY_EVENT_STS) ? {{(32-NPIPE){1'b0}}, not_ready_event_sts_r} :
    (AVS_ADDRESS == `UPES_A_NOT_READY_EVENT_ENB) ? {{(32-NPIPE){1'b0}}, not_ready_event_enb_r} :
    (AVS_ADDRESS == `UPES_A_BUFFER_EMPTY_EVENT_STS) ? {{(32-NPIPE){1'b0}}, buffer_empty_event_sts_r} :
    (AVS_ADDRESS == `UPES_A_BUFFER_EMPTY_EVENT_ENB) ? {{(32-NPIPE){1'b0}}, buffer_empty_event_enb_r} :
    (AVS_ADDRESS == `UPES_A_PIPE_RESP) ? {{(32-2*NPIPE){1'b0}}, resp_r} :
    (AVS_ADDRESS == `UPES_A_CTRL) ? {31'h0, HOST_ROLE} : 32'h0;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ack_r      <= 1'b0;
      rdata_r    <= 32'h0;
      not_ready_event_sts_r <= '0;
      buffer_empty_event_sts_r <= '0;
      not_ready_event_enb_r <= '0;
      buffer_empty_event_enb_r <= '0;
      main_enb_r <= 6'h0;
    end else begin
      ack_r <= acc;
      if (acc & AVS_READ) rdata_r <= rd_mux;
      not_ready_event_sts_r <= (not_ready_event_sts_r & ~not_ready_event_clr) | not_ready_event_set; // [R1]
      buffer_empty_event_sts_r <= (buffer_empty_event_sts_r & ~buffer_empty_event_clr) | buffer_empty_event_set; // [R12]
      if (wr & AVS_ADDRESS == `UPES_A_NOT_READY_EVENT_ENB & AVS_BYTEENABLE[0])
        not_ready_event_enb_r <= AVS_WRITEDATA[NPIPE-1:0];
      if (wr & AVS_ADDRESS == `UPES_A_BUFFER_EMPTY_EVENT_ENB & AVS_BYTEENABLE[0])
        buffer_empty_event_enb_r <= AVS_WRITEDATA[NPIPE-1:0];
      if (wr & AVS_ADDRESS == `UPES_A_MAIN_ENB & AVS_BYTEENABLE[0])
        main_enb_r <= AVS_WRITEDATA[5:0];
    end
  end

  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  not_ready_event_set_a: assert property (not_ready_event_set[2] |=> not_ready_event_sts_r[2]) // [R1]
    else $error("not-ready status not set");
  setup_quiet_a: assert property (ev & HOST_ROLE & LINK_EV.in_setup |-> not_ready_event_set == '0) // [R2]
    else $error("not-ready in setup");
  stall_resp_a: assert property (stall_ev & pbuf & p == 3'h4 |=> resp_r[9:8] == `UPES_RESP_STALL) // [R4]
    else $error("stall response missing");
  buffer_empty_event_set_a: assert property (buffer_empty_event_set[1] |=> buffer_empty_event_sts_r[1]) // [R7]
    else $error("empty status not set");
  buffer_empty_event_keep_a: assert property (buffer_empty_event_sts_r[0] & wr_bsts & AVS_WRITEDATA[0] |=> buffer_empty_event_sts_r[0]) // [R12]
    else $error("write one cleared status");
  seq_err_a: assert property (ctl_err |=> resp_r[1] && ctsq_r == `UPES_STG_ERR) // [R17]
    else $error("sequence error not stalled");
  err_hold_a: assert property (held & ~main_clr_stage_transition_event |=> ctsq_r == `UPES_STG_ERR) // [R22]
    else $error("error code not held");
  host_no_dev_a: assert property (HOST_ROLE |=> $stable(dvsq_r)) // [R13]
    else $error("device state moved in host role");
  irq_a: assert property (USB_IRQ == |(main_flags & main_enb_r)) // [R23]
    else $error("interrupt mismatch");
  ack_a: assert property (AVS_READ & ~ack_r |=> ~AVS_WAITREQUEST)
    else $error("no answer");
  c_not_ready_event_c: cover property (not_ready_event_set != '0 ##1 USB_IRQ);
  c_sequence_error_flag_c: cover property (ctl_err);
  c_hold_c: cover property (setup_pend_r ##1 setup_go);
endmodule // upes_top
`default_nettype wire

// *** bench/upes_peer.sv ***
// usb bus peer model issuing link, control and device events
`timescale 1ns/1ps
`default_nettype none
module upes_peer
  import upes_pkg::*;
(
  input  wire logic        mclk,
  output var upes_link_ev_t link_ev,
  output var logic         link_ev_valid,
  output var upes_ctl_ev_t  ctl_ev,
  output var upes_dev_ev_t  dev_ev
);
  initial begin
    link_ev = '1;
    link_ev_valid = 1'b0;
    ctl_ev = '0;
    dev_ev = '0;
  end
  // one-cycle link event; fields scrambled once released
  task automatic lnk(input upes_link_ev_t e);
    @(posedge mclk);
    link_ev       <= e;
    link_ev_valid <= 1'b1;
    @(posedge mclk);
    link_ev       <= ~e;
    link_ev_valid <= 1'b0;
  endtask
  task automatic ctl(input upes_ctl_ev_t e);
    @(posedge mclk);
    ctl_ev <= e;
    @(posedge mclk);
    ctl_ev <= '0;
  endtask
  task automatic dev(input upes_dev_ev_t e);
    @(posedge mclk);
    dev_ev <= e;
    @(posedge mclk);
    dev_ev <= '0;
  endtask
endmodule // upes_peer
`default_nettype wire

// *** bench/test_upes_top.sv ***
// self-checking bench for the pipe event status block
`timescale 1ns/1ps
`default_nettype none
module test_upes_top import upes_pkg::*;;
  logic          mclk = 1'b0;
  logic          rst_n = 1'b0;
  logic          host_role = 1'b0;
  upes_link_ev_t link_ev;
  logic          link_ev_valid;
  upes_ctl_ev_t  ctl_ev;
  upes_dev_ev_t  dev_ev;
  logic          buf_clear = 1'b0;
  logic [2:0]    buf_clear_pipe = 3'h0;
  logic [3:0]    avs_address = 4'h0;
  logic          avs_read = 1'b0;
  logic          avs_write = 1'b0;
  logic [31:0]   avs_writedata = 32'h0;
  logic [3:0]    avs_byteenable = 4'hF;
  logic [31:0]   avs_readdata;
  logic          avs_waitrequest;
  logic          stall_reply;
  logic          usb_irq;
  logic          stl_seen = 1'b0;
  logic          rb;
  logic [63:0]   rq[$];
  logic [8:0]    cs[7][4];
  logic [2:0]    ds[5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h3};
  int            error_cnt = 0;
  int            n_checks = 0;
  int            cyc = 0;
  int            i;
  int            j;
  int            seed = 32'h6167367A;
  upes_top #(.NPIPE(8)) upes_top_i (
    .MCLK(mclk), .RST_N(rst_n), .HOST_ROLE(host_role), .LINK_EV(link_ev),
    .LINK_EV_VALID(link_ev_valid), .CTL_EV(ctl_ev), .DEV_EV(dev_ev), .BUF_CLEAR(buf_clear),
    .BUF_CLEAR_PIPE(buf_clear_pipe), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .STALL_REPLY(stall_reply), .USB_IRQ(usb_irq));
  upes_peer upes_peer_i (.mclk(mclk), .link_ev(link_ev), .link_ev_valid(link_ev_valid),
    .ctl_ev(ctl_ev), .dev_ev(dev_ev));
  always #2.5 mclk = ~mclk;
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, ex, got);
    end
  endtask
  task automatic bus(input logic r, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address   <= a;
    avs_read      <= r;
    avs_write     <= !r;
    avs_writedata <= d;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] ex, input logic [31:0] m);
    rq.push_back({m, ex});
    bus(1'b1, a, 32'h0);
  endtask
  // flags msb first: tx, setup, fail, ok, stall, in, nak, toggle, err, data, done, zlp, dbl, big
  task automatic lk(input logic [2:0] p, input logic [13:0] f);
    upes_peer_i.lnk({p, f});
  endtask
  // read data compared against the oldest note
  always @(posedge mclk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      check("readdata", rq[0][31:0], avs_readdata & rq[0][63:32]);
      void'(rq.pop_front());
    end
    if (stall_reply === 1'b1) stl_seen <= 1'b1;
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    cs = '{'{9'h180, 9'h010, 9'h000, 9'h000},
           '{9'h180, 9'h024, 9'h010, 9'h020},
           '{9'h180, 9'h024, 9'h010, 9'h018},
           '{9'h100, 9'h020, 9'h000, 9'h000},
           '{9'h100, 9'h018, 9'h000, 9'h000},
           '{9'h100, 9'h012, 9'h020, 9'h010},
           '{9'h140, 9'h010, 9'h000, 9'h000}};
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    for (i = 0; i < 9; i++) rd(i[3:0], 32'h0, 32'hFFFFFFFF);
    wr(4'h8, $random(seed));
    rd(4'h8, 32'h0, 32'hFFFFFFFF);
    wr(4'h6, 32'h5555);
    wr(4'h1, 32'h3F);
    wr(4'h3, 32'hFF);
    wr(4'h5, 32'hFF);
    avs_byteenable <= 4'hE;
    wr(4'h1, 32'h0);
    rd(4'h1, 32'h3F, 32'h3F);
    avs_byteenable <= 4'hF;
    check("irq", 32'h0, {31'h0, usb_irq});
    lk(3'h2, 14'h2100);
    lk(3'h7, 14'h2110);
    rd(4'h2, 32'h4, 32'hFF);
    rd(4'h0, 32'h1, 32'h1);
    check("irq", 32'h1, {31'h0, usb_irq});
    wr(4'h2, 32'h0);
    lk(3'h5, 14'h00C0);
    lk(3'h5, 14'h00A0);
    rd(4'h2, 32'h0, 32'hFF);
    lk(3'h5, 14'h0080);
    rd(4'h2, 32'h20, 32'hFF);
    wr(4'h2, 32'h0);
    lk(3'h1, 14'h200A);
    lk(3'h1, 14'h200C);
    buf_clear_pipe <= 3'h1;
    buf_clear <= 1'b1;
    lk(3'h1, 14'h2008);
    buf_clear <= 1'b0;
    rd(4'h4, 32'h0, 32'hFF);
    lk(3'h1, 14'h2008);
    rd(4'h4, 32'h2, 32'hFF);
    rd(4'h0, 32'h2, 32'h2);
    wr(4'h4, 32'hFF);
    rd(4'h4, 32'h2, 32'hFF);
    wr(4'h4, 32'h0);
    rd(4'h4, 32'h0, 32'hFF);
    lk(3'h6, 14'h0021);
    lk(3'h6, 14'h1001);
    rd(4'h4, 32'h0, 32'hFF);
    check("stall", 32'h0, {31'h0, stl_seen});
    lk(3'h6, 14'h0001);
    rd(4'h4, 32'h40, 32'hFF);
    rd(4'h6, 32'h3000, 32'h3000);
    check("stall", 32'h1, {31'h0, stl_seen});
    wr(4'h4, 32'h0);
    for (i = 0; i < 5; i++) begin
      upes_peer_i.dev(5'h10 >> i);
      rd(4'h0, {21'h0, ds[i], 8'h0} | ((i == 4) ? 32'h10 : 32'h4), 32'h714);
      wr(4'h0, 32'h0);
    end
    upes_peer_i.ctl(9'h100);
    for (j = 0; j < 3; j++) upes_peer_i.ctl(9'h012);
    rd(4'h0, 32'h3000, 32'h7020);
    upes_peer_i.ctl(9'h020);
    rd(4'h0, 32'h4008, 32'h7008);
    upes_peer_i.ctl(9'h001);
    rd(4'h0, 32'h0, 32'h7000);
    wr(4'h0, 32'h0);
    for (i = 0; i < 7; i++) begin
      wr(4'h6, 32'h5555);
      for (j = 0; j < 4; j++) if (cs[i][j] != 9'h0) upes_peer_i.ctl(cs[i][j]);
      rd(4'h0, 32'h6028, 32'h7028);
      rd(4'h6, 32'h2, 32'h2);
      if (i == 6) begin
        upes_peer_i.ctl(9'h140);
        rd(4'h0, 32'h6000, 32'h7000);
      end
      wr(4'h0, 32'h0);
    end
    rd(4'h0, 32'h8, 32'h8);
    @(posedge mclk);
    host_role <= 1'b1;
    rd(4'h7, 32'h1, 32'h1);
    wr(4'h6, 32'h5555);
    wr(4'h2, 32'h0);
    for (j = 0; j < 5; j++) begin
      rb = ($random(seed) % 2) != 0;
      lk(3'h3, {rb, (j == 2) ? 13'h0400 : 13'h0800});
    end
    rd(4'h2, 32'h0, 32'hFF);
    lk(3'h3, {rb, 13'h0800});
    rd(4'h2, 32'h8, 32'hFF);
    rd(4'h6, 32'h0, 32'hC0);
    for (j = 0; j < 3; j++) lk(3'h4, 14'h1800);
    rd(4'h2, 32'h8, 32'hFF);
    lk(3'h4, 14'h0200);
    rd(4'h2, 32'h18, 32'hFF);
    rd(4'h6, 32'h300, 32'h300);
    stl_seen = 1'b0;
    lk(3'h7, 14'h0001);
    rd(4'h4, 32'h80, 32'hFF);
    check("stall", 32'h0, {31'h0, stl_seen});
    upes_peer_i.dev(5'h10);
    rd(4'h0, 32'h0, 32'h4);
    complete_run();
  end
endmodule // test_upes_top
`default_nettype wire
